// ---- hw/cpuexc_pkg.sv ----
// Constants, types and field layouts shared by the exception sequencer files.
// Assumes a 20 MHz core clock and a 32-bit Avalon-MM register port.

package cpuexc_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_STATUS = 6'h00;
    localparam logic [5:0] OFS_SPC = 6'h04;
    localparam logic [5:0] OFS_SSW = 6'h08;
    localparam logic [5:0] OFS_VBASE = 6'h0c;
    localparam logic [5:0] OFS_EXCODE = 6'h10;
    localparam logic [5:0] OFS_INTCODE = 6'h14;
    localparam logic [5:0] OFS_INTCODE2 = 6'h18;
    localparam logic [5:0] OFS_FAULT = 6'h1c;
    localparam logic [5:0] OFS_PAGE_ENTRY_HIGH = 6'h20;
    localparam logic [5:0] OFS_MMUCTL = 6'h24;
    localparam logic [5:0] OFS_CORESTATE = 6'h28;
    // ------------------------------------------------------------
    // Status word layout and reset value
    // ------------------------------------------------------------
    localparam int SR_MD = 30;
    localparam int SR_RB = 29;
    localparam int SR_BL = 28;
    localparam int SR_IM_LSB = 4;
    localparam logic [31:0] SR_RESET = 32'h700000f0;
    localparam int PAGE_ENTRY_HIGH_VPN_LSB = 10;
    localparam int WAY_W = 2;
    // ------------------------------------------------------------
    // Event codes, vectors and addresses
    // ------------------------------------------------------------
    localparam logic [11:0] CODE_POR = 12'h000;
    localparam logic [11:0] CODE_MRST = 12'h020;
    localparam logic [11:0] CODE_MISS_RD = 12'h040;
    localparam logic [11:0] CODE_MISS_WR = 12'h060;
    localparam logic [11:0] CODE_INIT_WR = 12'h080;
    localparam logic [11:0] CODE_PROT_RD = 12'h0a0;
    localparam logic [11:0] CODE_PROT_WR = 12'h0c0;
    localparam logic [11:0] CODE_ADR_RD = 12'h0e0;
    localparam logic [11:0] CODE_ADR_WR = 12'h100;
    localparam logic [31:0] RESET_PC = 32'ha0000000;
    localparam logic [31:0] VBASE_RESET = 32'h00000000;
    localparam logic [31:0] VEC_GEN = 32'h00000100;
    localparam logic [31:0] VEC_MISS = 32'h00000400;
    localparam logic [31:0] VEC_INT = 32'h00000600;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {CX_RUN = 2'b00, CX_DRAIN = 2'b01, CX_RESET = 2'b10} cpuexc_state_e;
    typedef enum logic [1:0] {SZ_BYTE = 2'b00, SZ_WORD = 2'b01, SZ_LONG = 2'b10} cpuexc_size_e;
    typedef struct packed {
        logic valid;
        logic write;
        logic fetch;
        cpuexc_size_e size;
        logic [31:0] vaddr;
    } cpuexc_acc_s;
    typedef struct packed {
        logic hit;
        logic [WAY_W-1:0] way;
        logic valid_bit;
        logic dirty_bit;
        logic [1:0] prot;
        logic all_valid;
    } cpuexc_tlb_s;
    typedef struct packed {
        logic fault;
        logic tlb;
        logic miss;
        logic [11:0] code;
        logic [WAY_W-1:0] rc;
    } cpuexc_fault_s;
endpackage : cpuexc_pkg

// ---- hw/cpuexc_sync2.sv ----
// Two-flop synchroniser for pin levels.
// Assumes inputs are levels from outside the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module cpuexc_sync2 #(
    parameter int W = 2,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // Only the second stage reads the first one
    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q;
endmodule : cpuexc_sync2
`default_nettype wire

// ---- hw/cpuexc_mmu_check.sv ----
// Combinational classifier of memory access faults.
// Assumes translation results arrive in the same cycle as the access.
`timescale 1ns/1ps
`default_nettype none
module cpuexc_mmu_check
    import cpuexc_pkg::*;
(
    input wire cpuexc_acc_s i_acc,
    input wire cpuexc_tlb_s i_tlb,
    input wire logic i_priv,
    input wire logic [WAY_W-1:0] i_rc,
    output cpuexc_fault_s o_fault
);
    logic adr_err;
    logic prot_ok;

    always_comb begin
        adr_err = (i_acc.fetch && i_acc.vaddr[0])
            || (i_acc.size == SZ_WORD && i_acc.vaddr[0])
            || (i_acc.size == SZ_LONG && i_acc.vaddr[1:0] != 2'h0)
            || (!i_priv && i_acc.vaddr[31]);
        if (i_priv) begin
            prot_ok = !i_acc.write || i_tlb.prot[0];
        end else begin
            prot_ok = i_tlb.prot[1] && (!i_acc.write || i_tlb.prot[0]);
        end
        o_fault = '0;
        o_fault.rc = i_rc;
        if (i_acc.valid) begin
            // Address errors (misalignment, user access with vaddr[31] set) win: no translation is trusted for them
            if (adr_err) begin
                o_fault.fault = 1'b1;
                o_fault.code = i_acc.write ? CODE_ADR_WR : CODE_ADR_RD;
            end else if (!i_tlb.hit) begin
                o_fault.fault = 1'b1;
                o_fault.tlb = 1'b1;
                o_fault.miss = 1'b1;
                o_fault.code = i_acc.write ? CODE_MISS_WR : CODE_MISS_RD;
                o_fault.rc = i_tlb.all_valid ? i_rc + {{(WAY_W-1){1'b0}}, 1'b1} : '0;
            end else if (!i_tlb.valid_bit) begin
                o_fault.fault = 1'b1;
                o_fault.tlb = 1'b1;
                o_fault.code = i_acc.write ? CODE_MISS_WR : CODE_MISS_RD;
                o_fault.rc = i_tlb.way;
            end else if (!prot_ok) begin
                o_fault.fault = 1'b1;
                o_fault.tlb = 1'b1;
                o_fault.code = i_acc.write ? CODE_PROT_WR : CODE_PROT_RD;
                o_fault.rc = i_tlb.way;
            end else if (i_acc.write && !i_tlb.dirty_bit) begin
                o_fault.fault = 1'b1;
                o_fault.tlb = 1'b1;
                o_fault.code = CODE_INIT_WR;
                o_fault.rc = i_tlb.way;
            end
        end
    end
endmodule : cpuexc_mmu_check
`default_nettype wire

// ---- hw/cpuexc_seq.sv ----
// Exception and reset sequencer: status word, saved state, event codes,
// fault capture and fetch redirection, with an Avalon-MM register port.
// Assumes the pipeline flags instruction completion and reports its pc.
`timescale 1ns/1ps
`default_nettype none
module cpuexc_seq
    import cpuexc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_power_on_reset_n,
    input wire logic i_manual_reset_n,
    input wire logic i_dbg_reset,
    input wire logic i_mem_busy,
    input wire logic i_instr_done,
    input wire logic [31:0] i_pc,
    input wire logic i_irq_req,
    input wire logic [3:0] i_irq_level,
    input wire logic [11:0] i_irq_code,
    input wire logic i_exc_req,
    input wire logic [11:0] i_exc_code,
    input wire cpuexc_acc_s i_acc,
    input wire cpuexc_tlb_s i_tlb,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_redirect,
    output logic [31:0] o_redirect_pc,
    output logic o_cpu_reset,
    output logic [31:0] o_status_word,
    output logic o_cpu_state_out0,
    output logic o_cpu_state_out1
);
    // ------------------------------------------------------------
    // Pin synchronisers and fault classifier
    // ------------------------------------------------------------
    logic [1:0] pins_s;
    cpuexc_fault_s fault;
    cpuexc_state_e state_q, state_d;
    logic [31:0] sr_q, sr_d, spc_q, spc_d, ssw_q, ssw_d, vbase_q, vbase_d;
    logic [11:0] excode_q, excode_d, intcode_q, intcode_d, intcode2_q, intcode2_d;
    logic [31:0] fault_q, fault_d, page_entry_high_q, page_entry_high_d;
    logic [WAY_W-1:0] rc_q, rc_d;
    logic redir_q, redir_d, cpurst_q, cpurst_d, stout_q, stout_d;
    logic [31:0] redir_pc_q, redir_pc_d, rdata_q, rdata_d;
    logic wait_q, wait_d;

    cpuexc_sync2 #(.W(2), .RST_VAL(2'h3)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_power_on_reset_n, i_manual_reset_n}),
        .o_sync(pins_s)
    );

    cpuexc_mmu_check u_check (
        .i_acc(i_acc),
        .i_tlb(i_tlb),
        .i_priv(sr_q[SR_MD]),
        .i_rc(rc_q),
        .o_fault(fault)
    );

    // ------------------------------------------------------------
    // Sequencing and register port
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    logic por_evt, mrst_evt, wr_go, enter_rst, exc_go, irq_go;
    logic [11:0] rst_code, exc_code;
    logic [31:0] exc_vec, wv, wv2, wv3;

    always_comb begin
        state_d = state_q;
        sr_d = sr_q;
        spc_d = spc_q;
        ssw_d = ssw_q;
        vbase_d = vbase_q;
        excode_d = excode_q;
        intcode_d = intcode_q;
        intcode2_d = intcode2_q;
        fault_d = fault_q;
        page_entry_high_d = page_entry_high_q;
        rc_d = rc_q;
        redir_d = 1'b0;
        redir_pc_d = redir_pc_q;
        por_evt = !pins_s[1] || i_dbg_reset;
        mrst_evt = !pins_s[0];
        rst_code = por_evt ? CODE_POR : CODE_MRST;
        enter_rst = 1'b0;
        exc_go = 1'b0;
        irq_go = 1'b0;
        exc_code = i_exc_code;
        exc_vec = VEC_GEN;
        // Software writes land first so that hardware events override them
        wr_go = i_avs_write && !wait_q;
        // Code registers keep only the low twelve bits of the merged word
        wv = merge({20'h0, excode_q}, i_avs_writedata, i_avs_byteenable);
        wv2 = merge({20'h0, intcode_q}, i_avs_writedata, i_avs_byteenable);
        wv3 = merge({20'h0, intcode2_q}, i_avs_writedata, i_avs_byteenable);
        if (wr_go) begin
            unique case (i_avs_address)
                OFS_STATUS: sr_d = merge(sr_q, i_avs_writedata, i_avs_byteenable);
                OFS_SPC: spc_d = merge(spc_q, i_avs_writedata, i_avs_byteenable);
                OFS_SSW: ssw_d = merge(ssw_q, i_avs_writedata, i_avs_byteenable);
                OFS_VBASE: vbase_d = merge(vbase_q, i_avs_writedata, i_avs_byteenable);
                OFS_EXCODE: excode_d = wv[11:0];
                OFS_INTCODE: intcode_d = wv2[11:0];
                OFS_INTCODE2: intcode2_d = wv3[11:0];
                OFS_FAULT: fault_d = merge(fault_q, i_avs_writedata, i_avs_byteenable);
                OFS_PAGE_ENTRY_HIGH: page_entry_high_d = merge(page_entry_high_q, i_avs_writedata, i_avs_byteenable);
                OFS_MMUCTL: begin
                    if (i_avs_byteenable[0]) begin
                        rc_d = i_avs_writedata[WAY_W-1:0];
                    end
                end
                default: ;
            endcase
        end
        unique case (state_q)
            CX_RUN: begin
                if (por_evt) begin
                    enter_rst = 1'b1;
                end else if (mrst_evt) begin
                    if (i_mem_busy) begin
                        state_d = CX_DRAIN;
                    end else begin
                        enter_rst = 1'b1;
                    end
                end else if (fault.fault) begin
                    exc_go = 1'b1;
                    exc_code = fault.code;
                    exc_vec = fault.miss ? VEC_MISS : VEC_GEN;
                    if (!sr_q[SR_BL]) begin
                        fault_d = i_acc.vaddr;
                        if (fault.tlb) begin
                            page_entry_high_d = {i_acc.vaddr[31:PAGE_ENTRY_HIGH_VPN_LSB], page_entry_high_q[PAGE_ENTRY_HIGH_VPN_LSB-1:0]};
                            rc_d = fault.rc;
                        end
                    end
                end else if (i_exc_req) begin
                    exc_go = 1'b1;
                end else if (i_instr_done && i_irq_req && !sr_q[SR_BL]
                        && i_irq_level > sr_q[SR_IM_LSB +: 4]) begin
                    irq_go = 1'b1;
                end
            end
            CX_DRAIN: begin
                // A power-on reset cuts the pending access short
                if (por_evt || !i_mem_busy) begin
                    enter_rst = 1'b1;
                end
            end
            CX_RESET: begin
                sr_d = SR_RESET;
                vbase_d = VBASE_RESET;
                if (por_evt) begin
                    excode_d = CODE_POR;
                end else if (!mrst_evt) begin
                    state_d = CX_RUN;
                    redir_d = 1'b1;
                    redir_pc_d = RESET_PC;
                end
            end
            default: state_d = CX_RESET;
        endcase
        if (enter_rst) begin
            state_d = CX_RESET;
            sr_d = SR_RESET;
            vbase_d = VBASE_RESET;
            excode_d = rst_code;
        end
        if (exc_go) begin
            if (sr_q[SR_BL]) begin
                // Blocked: only the status word and vector base are reinitialised, other registers keep values
                sr_d = SR_RESET;
                vbase_d = VBASE_RESET;
                redir_d = 1'b1;
                redir_pc_d = RESET_PC;
            end else begin
                spc_d = i_pc;
                ssw_d = sr_q;
                sr_d[SR_BL] = 1'b1;
                sr_d[SR_MD] = 1'b1;
                sr_d[SR_RB] = 1'b1;
                excode_d = exc_code;
                redir_d = 1'b1;
                redir_pc_d = vbase_q + exc_vec;
            end
        end
        if (irq_go) begin
            spc_d = i_pc;
            ssw_d = sr_q;
            sr_d[SR_BL] = 1'b1;
            sr_d[SR_MD] = 1'b1;
            sr_d[SR_RB] = 1'b1;
            intcode_d = i_irq_code;
            intcode2_d = i_irq_code;
            redir_d = 1'b1;
            redir_pc_d = vbase_q + VEC_INT;
        end
        cpurst_d = (state_d == CX_RESET);
        stout_d = (state_d != CX_RUN);
        // Bus answer: one wait cycle, then the request is taken
        wait_d = !((i_avs_read || i_avs_write) && wait_q);
        rdata_d = rdata_q;
        if (i_avs_read && wait_q) begin
            unique case (i_avs_address)
                OFS_STATUS: rdata_d = sr_q;
                OFS_SPC: rdata_d = spc_q;
                OFS_SSW: rdata_d = ssw_q;
                OFS_VBASE: rdata_d = vbase_q;
                OFS_EXCODE: rdata_d = {20'h0, excode_q};
                OFS_INTCODE: rdata_d = {20'h0, intcode_q};
                OFS_INTCODE2: rdata_d = {20'h0, intcode2_q};
                OFS_FAULT: rdata_d = fault_q;
                OFS_PAGE_ENTRY_HIGH: rdata_d = page_entry_high_q;
                OFS_MMUCTL: rdata_d = {{(32-WAY_W){1'b0}}, rc_q};
                OFS_CORESTATE: rdata_d = {27'h0, i_mem_busy, pins_s, state_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= CX_RESET;
            sr_q <= SR_RESET;
            spc_q <= 32'h0;
            ssw_q <= 32'h0;
            vbase_q <= VBASE_RESET;
            excode_q <= CODE_POR;
            intcode_q <= 12'h0;
            intcode2_q <= 12'h0;
            fault_q <= 32'h0;
            page_entry_high_q <= 32'h0;
            rc_q <= '0;
            redir_q <= 1'b0;
            redir_pc_q <= RESET_PC;
            cpurst_q <= 1'b1;
            stout_q <= 1'b1;
            rdata_q <= 32'h0;
            wait_q <= 1'b1;
        end else begin
            state_q <= state_d;
            sr_q <= sr_d;
            spc_q <= spc_d;
            ssw_q <= ssw_d;
            vbase_q <= vbase_d;
            excode_q <= excode_d;
            intcode_q <= intcode_d;
            intcode2_q <= intcode2_d;
            fault_q <= fault_d;
            page_entry_high_q <= page_entry_high_d;
            rc_q <= rc_d;
            redir_q <= redir_d;
            redir_pc_q <= redir_pc_d;
            cpurst_q <= cpurst_d;
            stout_q <= stout_d;
            rdata_q <= rdata_d;
            wait_q <= wait_d;
        end
    end

    assign o_avs_readdata = rdata_q;
    assign o_avs_waitrequest = wait_q;
    assign o_redirect = redir_q;
    assign o_redirect_pc = redir_pc_q;
    assign o_cpu_reset = cpurst_q;
    assign o_status_word = sr_q;
    assign o_cpu_state_out0 = stout_q;
    assign o_cpu_state_out1 = stout_q;
endmodule : cpuexc_seq
`default_nettype wire

// ---- tb/cpuexc_seq_monitor.sv ----
// Checker of the sequencer ports: resets, redirects, blocking.
// Assumes it is bound into cpuexc_seq and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cpuexc_seq_mon
    import cpuexc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_power_on_reset_n,
    input wire logic i_dbg_reset,
    input wire logic i_mem_busy,
    input wire logic i_instr_done,
    input wire logic i_exc_req,
    input wire cpuexc_acc_s i_acc,
    input wire logic o_redirect,
    input wire logic [31:0] o_redirect_pc,
    input wire logic o_cpu_reset,
    input wire logic [31:0] o_status_word,
    input wire logic o_cpu_state_out0,
    input wire logic o_cpu_state_out1
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    // Pins pass a two-flop sync, hence the four-sample window
    logic run;
    logic bl;
    assign run = !o_cpu_reset && !o_cpu_state_out0;
    assign bl = o_status_word[SR_BL];
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    property p_por; !i_power_on_reset_n [*4] |-> o_cpu_reset; endproperty
    a_por: assert property (p_por) else $error("no reset after pin");
    property p_outs; o_cpu_reset |-> o_cpu_state_out0 && o_cpu_state_out1 && o_status_word == SR_RESET; endproperty
    a_outs: assert property (p_outs) else $error("reset outputs wrong");
    property p_fetch; $fell(o_cpu_reset) |-> ##[0:1] (o_redirect && o_redirect_pc == RESET_PC); endproperty
    a_fetch: assert property (p_fetch) else $error("no reset fetch");
    property p_idle;
        run && !$fell(o_cpu_reset) && !i_instr_done && !i_exc_req && !i_acc.valid && !i_dbg_reset |=> !o_redirect;
    endproperty
    a_idle: assert property (p_idle) else $error("redirect mid instruction");
    property p_block; run && bl && !$fell(o_cpu_reset) && !i_exc_req && !i_acc.valid |=> !o_redirect; endproperty
    a_block: assert property (p_block) else $error("taken while blocked");
    property p_blexc; run && bl && i_exc_req && !i_dbg_reset |=> o_redirect && o_redirect_pc == RESET_PC; endproperty
    a_blexc: assert property (p_blexc) else $error("blocked exception");
    property p_exc; run && !bl && i_exc_req && !i_acc.valid |=> o_redirect && o_status_word[30:28] == 3'b111; endproperty
    a_exc: assert property (p_exc) else $error("exception entry");
    property p_drain; o_cpu_state_out0 && !o_cpu_reset && i_mem_busy |=> !o_cpu_reset; endproperty
    a_drain: assert property (p_drain) else $error("reset before access end");
    c_irq: cover property (run && i_instr_done && !bl ##1 o_redirect);
    c_drain: cover property (o_cpu_state_out0 && !o_cpu_reset && i_mem_busy);
    c_blexc: cover property (run && bl && i_exc_req);
endmodule : cpuexc_seq_mon
bind cpuexc_seq cpuexc_seq_mon i_cpuexc_seq_mon (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_power_on_reset_n(i_power_on_reset_n), .i_dbg_reset(i_dbg_reset), .i_mem_busy(i_mem_busy),
    .i_instr_done(i_instr_done), .i_exc_req(i_exc_req), .i_acc(i_acc), .o_redirect(o_redirect),
    .o_redirect_pc(o_redirect_pc), .o_cpu_reset(o_cpu_reset), .o_status_word(o_status_word),
    .o_cpu_state_out0(o_cpu_state_out0), .o_cpu_state_out1(o_cpu_state_out1));
`default_nettype wire

// ---- tb/cpuexc_pipe_model.sv ----
// Pipeline and memory model facing the sequencer.
// Assumes one clock; the bench starts an access with i_busy_go.
`timescale 1ns/1ps
`default_nettype none
module cpuexc_pipe_model (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_busy_go,
    output logic o_mem_busy,
    output logic o_instr_done
);
    // ----------------------------------------
    // Access length and instruction pacing
    // ----------------------------------------
    // A long access keeps a manual reset waiting past the sync delay
    logic [3:0] busy_q;
    logic [1:0] step_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_q <= 4'h0;
            step_q <= 2'h0;
        end else begin
            busy_q <= i_busy_go ? 4'hc : busy_q - 4'(busy_q != 4'h0);
            step_q <= step_q + 2'h1;
        end
    end
    assign o_mem_busy = busy_q != 4'h0;
    assign o_instr_done = step_q == 2'h3;
endmodule : cpuexc_pipe_model
`default_nettype wire

// ---- tb/cpuexc_seq_tb.sv ----
// Self-checking bench of the sequencer with a pipeline model.
// Assumes the offsets of cpuexc_pkg and the hand-over timing.
`timescale 1ns/1ps
`default_nettype none
module cpuexc_seq_tb
    import cpuexc_pkg::*;
();
    // ----------------------------------------
    // Stimulus, design and checking
    // ----------------------------------------
    logic clk = 1'b0, rst_n = 1'b0, por_n = 1'b1, mrst_n = 1'b1, dbg = 1'b0, go = 1'b0, irq = 1'b0;
    logic exc = 1'b0, rd = 1'b0, wr = 1'b0, busy, done, wreq, redir, cres, so0, so1;
    logic [3:0] lvl = 4'h1;
    logic [11:0] icode = 12'h200;
    logic [5:0] adr = 6'h0;
    logic [31:0] wd = 32'h0, pcv = 32'h0, rdat, rpc, sw, vb, va;
    cpuexc_acc_s acc = '0;
    cpuexc_tlb_s tlb = '0;
    logic [31:0] q_pc[$], q_rd[$];
    int n_fail = 0, checked = 0;
    cpuexc_seq i_cpuexc_seq (.i_core_clk(clk), .i_rst_n(rst_n), .i_power_on_reset_n(por_n),
        .i_manual_reset_n(mrst_n), .i_dbg_reset(dbg), .i_mem_busy(busy), .i_instr_done(done),
        .i_pc(pcv), .i_irq_req(irq), .i_irq_level(lvl), .i_irq_code(icode), .i_exc_req(exc),
        .i_exc_code(12'h160), .i_acc(acc), .i_tlb(tlb), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .o_redirect(redir), .o_redirect_pc(rpc), .o_cpu_reset(cres),
        .o_status_word(sw), .o_cpu_state_out0(so0), .o_cpu_state_out1(so1));
    cpuexc_pipe_model i_cpuexc_pipe_model (.i_core_clk(clk), .i_rst_n(rst_n), .i_busy_go(go),
        .o_mem_busy(busy), .o_instr_done(done));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic test_done;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    task automatic bail;
        n_fail++;
        test_done();
    endtask : bail
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (e !== g) begin
            n_fail++;
            $display("unexpected at %0t: %h %h", $time, e, g);
        end
    endtask : cmp
    task automatic chk_pc(input logic [31:0] g);
        cmp(q_pc.size() > 0 ? q_pc.pop_front() : 32'hx, g);
    endtask : chk_pc
    task automatic chk_rd(input logic [31:0] g);
        cmp(q_rd.size() > 0 ? q_rd.pop_front() : 32'hx, g);
    endtask : chk_rd
    // Every redirect or read data beat must match the oldest note
    always @(posedge clk) begin
        if (rd === 1'b1 && wreq === 1'b0)
            chk_rd(rdat);
        if (redir === 1'b1)
            chk_pc(rpc);
    end
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        rd <= !w;
        wr <= w;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        rd <= 1'b0;
        wr <= 1'b0;
        if (wreq !== 1'b0)
            bail();
    endtask : bus
    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rdc
    task automatic settle;
        int n;
        n = 0;
        while (q_pc.size() != 0 && n < 60) begin
            @(posedge clk);
            n++;
        end
        if (q_pc.size() != 0)
            bail();
    endtask : settle
    task automatic kick(input logic [31:0] e, input logic d);
        q_pc.push_back(e);
        @(posedge clk);
        exc <= !d;
        dbg <= d;
        @(posedge clk);
        exc <= 1'b0;
        dbg <= 1'b0;
        settle();
    endtask : kick
    // Wf is {write, fetch}; t is {hit, way, valid, dirty, prot}
    task automatic mmu(input logic [1:0] wf, input cpuexc_size_e sz, input logic [31:0] a, input logic [6:0] t,
                       input logic md, input logic [11:0] c, input logic [31:0] v);
        bus(1'b1, OFS_STATUS, {1'b0, md, 30'h0});
        q_pc.push_back(vb + v);
        @(posedge clk);
        acc <= '{1'b1, wf[1], wf[0], sz, a};
        tlb <= {t, 1'b1};
        @(posedge clk);
        acc.valid <= 1'b0;
        settle();
        rdc(OFS_EXCODE, {20'h0, c});
        rdc(OFS_FAULT, a);
        rdc(OFS_PAGE_ENTRY_HIGH, {va[31:10], 10'h0});
    endtask : mmu
    task automatic pin(input logic p, input logic [11:0] c);
        int n;
        n = 0;
        q_pc.push_back(RESET_PC);
        @(posedge clk);
        go <= 1'b1;
        mrst_n <= 1'b0;
        por_n <= !p;
        @(posedge clk);
        go <= 1'b0;
        while (cres !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        if (cres !== 1'b1)
            bail();
        por_n <= 1'b1;
        mrst_n <= 1'b1;
        settle();
        rdc(OFS_EXCODE, {20'h0, c});
        rdc(OFS_VBASE, VBASE_RESET);
    endtask : pin
    initial begin
        va = $urandom(32'h64daba29);
        q_pc.push_back(RESET_PC);
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        rdc(OFS_STATUS, SR_RESET);
        rdc(OFS_EXCODE, 32'h0);
        rdc(6'h3c, 32'h0);
        vb = $urandom & 32'hfffff000;
        pcv <= $urandom & 32'hfffffffe;
        lvl <= 4'($urandom_range(15, 1));
        icode <= 12'($urandom) & 12'hfe0;
        bus(1'b1, OFS_VBASE, vb);
        bus(1'b1, OFS_STATUS, 32'h40000000);
        q_pc.push_back(vb + VEC_INT);
        irq <= 1'b1;
        settle();
        repeat (12) @(posedge clk);
        irq <= 1'b0;
        rdc(OFS_SPC, pcv);
        rdc(OFS_SSW, 32'h40000000);
        rdc(OFS_STATUS, 32'h70000000);
        rdc(OFS_INTCODE, {20'h0, icode});
        rdc(OFS_INTCODE2, {20'h0, icode});
        va = $urandom & 32'h7ffff000;
        mmu(2'b00, SZ_LONG, va, 7'b0001111, 1'b1, CODE_MISS_RD, VEC_MISS);
        rdc(OFS_MMUCTL, 32'h1);
        mmu(2'b10, SZ_LONG, va + 4, 7'b0001111, 1'b1, CODE_MISS_WR, VEC_MISS);
        mmu(2'b00, SZ_WORD, va + 2, 7'b1100111, 1'b1, CODE_MISS_RD, VEC_GEN);
        rdc(OFS_MMUCTL, 32'h2);
        mmu(2'b10, SZ_BYTE, va + 1, 7'b1011011, 1'b1, CODE_INIT_WR, VEC_GEN);
        mmu(2'b10, SZ_LONG, va, 7'b1001100, 1'b1, CODE_PROT_WR, VEC_GEN);
        mmu(2'b00, SZ_LONG, va, 7'b1001101, 1'b0, CODE_PROT_RD, VEC_GEN);
        mmu(2'b10, SZ_BYTE, va, 7'b1001110, 1'b0, CODE_PROT_WR, VEC_GEN);
        mmu(2'b01, SZ_WORD, va + 1, 7'b1001111, 1'b1, CODE_ADR_RD, VEC_GEN);
        mmu(2'b10, SZ_LONG, va + 2, 7'b1001111, 1'b1, CODE_ADR_WR, VEC_GEN);
        mmu(2'b00, SZ_LONG, va | RESET_PC, 7'b1001111, 1'b0, CODE_ADR_RD, VEC_GEN);
        bus(1'b1, OFS_STATUS, 32'h40000000);
        kick(vb + VEC_GEN, 1'b0);
        rdc(OFS_EXCODE, 32'h160);
        kick(RESET_PC, 1'b0);
        rdc(OFS_STATUS, SR_RESET);
        kick(RESET_PC, 1'b1);
        rdc(OFS_EXCODE, 32'h0);
        pin(1'b0, CODE_MRST);
        pin(1'b1, CODE_POR);
        test_done();
    end
endmodule : cpuexc_seq_tb
`default_nettype wire
